// File: bench/scc_channel_monitor.sv
`timescale 1ns/1ps
module scc_channel_monitor (
  input logic clk,
  input logic rst,
  input scc_pkg::scc_bus_s bus,
  input logic [scc_pkg::DW-1:0] rdata,
  input logic txd,
  input logic sclk,
  input logic tbEmpty,
  input logic rxDone
);
  import scc_pkg::*;
  logic [DW-1:0] ctrlSh;
  // shadow of control writes; hw flag bits are never looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlSh <= '0;
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrlSh <= bus.wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // checks
  a_rdata_idle:
    assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  a_pmw_readback:
    assert property ((bus.wr && bus.addr == ADDR_PMW) ##2
      (bus.rd && bus.addr == ADDR_PMW) |=>
      rdata == {7'h00, $past(bus.wdata[8:0], 3)})
    else $error("pulse control readback wrong");
  a_tbuf_upper:
    assert property ($past(bus.rd) && $past(bus.addr) == ADDR_TBUF
      |-> rdata[15:9] == 7'h00)
    else $error("transmit holding upper bits set");
  a_rbuf_upper:
    assert property ($past(bus.rd) && $past(bus.addr) == ADDR_RBUF
      |-> rdata[15:9] == 7'h00)
    else $error("receive holding upper bits set");
  a_norun_quiet:
    assert property (!ctrlSh[C_RUN] && !$past(ctrlSh[C_RUN])
      |-> !tbEmpty && !rxDone && sclk)
    else $error("activity without baud run");
  a_tbe_pulse:
    assert property (tbEmpty |-> ctrlSh[C_RUN] && !$past(tbEmpty))
    else $error("empty pulse without run or too long");
  a_rx_enable:
    assert property (rxDone |-> ctrlSh[C_REN])
    else $error("char delivered with receiver off");
  a_sclk_async:
    assert property (ctrlSh[2:0] != M_SYNC &&
      $past(ctrlSh[2:0]) != M_SYNC |-> sclk)
    else $error("shift clock moves in async mode");
endmodule : scc_channel_monitor

bind scc_channel scc_channel_monitor u_mon (
  .clk(clk),
  .rst(rst),
  .bus(bus),
  .rdata(rdata),
  .txd(txd),
  .sclk(sclk),
  .tbEmpty(tbEmpty),
  .rxDone(rxDone)
);

// File: bench/scc_remote.sv
`timescale 1ns/1ps
module scc_remote #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic lineIn,
  input wire logic listen,
  input wire logic [3:0] nBits,
  output logic lineOut
);
  logic [8:0] frames[$];
  int starts[$];
  int nFrames = 0;
  int cyc = 0;
  logic [8:0] v;
  int t0;
  initial lineOut = 1'b1;
  always @(posedge clk) cyc <= cyc + 1;
  // ==========
  // far-side sender: start low, lsb first, one stop
  task automatic send(input logic [8:0] d, input logic [3:0] n);
    @(posedge clk);
    lineOut <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      lineOut <= d[i];
      repeat (BIT) @(posedge clk);
    end
    lineOut <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask : send
  // ==========
  // far-side receiver, mid-cell sampling, no noise filter
  always begin
    @(negedge lineIn);
    if (listen) begin
      t0 = cyc;
      v = '0;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < nBits; i++) begin
        repeat (BIT) @(posedge clk);
        v[i] = lineIn;
      end
      repeat (BIT) @(posedge clk);
      frames.push_back(v);
      starts.push_back(t0);
      nFrames++;
    end
  end
endmodule : scc_remote

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import scc_pkg::*;
  logic clk;
  logic rst;
  scc_bus_s bus;
  logic [DW-1:0] rdata;
  logic rxd;
  logic txd;
  logic sclk;
  logic tbEmpty;
  logic rxDone;
  logic errIrq;
  logic listen;
  logic [3:0] peerBits;
  int errors = 0;
  int n_compared = 0;
  int tbeCnt = 0;
  int rxCnt = 0;
  int errCnt = 0;

  scc_channel DUT (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .rxd(rxd), .txd(txd), .sclk(sclk), .tbEmpty(tbEmpty),
    .rxDone(rxDone), .errIrq(errIrq));
  scc_remote peer (.clk(clk), .lineIn(txd), .listen(listen),
    .nBits(peerBits), .lineOut(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tbEmpty === 1'b1) tbeCnt <= tbeCnt + 1;
    if (rxDone === 1'b1) rxCnt <= rxCnt + 1;
    if (errIrq === 1'b1) errCnt <= errCnt + 1;
  end
  // ==========
  // helpers
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd
  function automatic int cnt(input int s);
    return s == 0 ? tbeCnt : s == 1 ? rxCnt : peer.nFrames;
  endfunction : cnt
  task automatic waitFor(input int s, input int goal, input int lim);
    for (int k = 0; k < lim && cnt(s) < goal; k++) @(negedge clk);
    if (cnt(s) < goal) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cnt(s), goal);
      summarize();
    end
  endtask : waitFor
  task automatic pulseW(output int w);
    w = 0;
    for (int k = 0; k < 400 && txd !== 1'b1; k++) @(negedge clk);
    while (txd === 1'b1 && w < 100) begin
      @(negedge clk);
      w++;
    end
  endtask : pulseW
  // ==========
  // scenarios
  task automatic t_regs();
    logic [15:0] v;
    for (int a = 0; a < 6; a++) begin
      rd(4'(a), v);
      chk(v, 16'h0000);
    end
    rd(4'h9, v);
    chk(v, 16'h0000);
    wr(ADDR_PMW, 16'hffff);
    rd(ADDR_PMW, v);
    chk(v, 16'h01ff);
    wr(ADDR_PMW, 16'h0000);
  endtask : t_regs
  task automatic t_tx();
    int g;
    g = tbeCnt + 1;
    listen <= 1'b1;
    wr(ADDR_CTRL, 16'h0301);
    wr(ADDR_TBUF, 16'hfe5a);
    waitFor(0, g, 20);
    wr(ADDR_TBUF, 16'h01a5);
    waitFor(2, 2, 1000);
    chk(16'(peer.frames[0]), 16'h005a);
    chk(16'(peer.frames[1]), 16'h00a5);
    chk(16'(peer.starts[1] - peer.starts[0]), 16'h0140);
  endtask : t_tx
  task automatic t_rx();
    logic [15:0] v;
    int r;
    int e;
    r = rxCnt;
    e = errCnt;
    wr(ADDR_CTRL, 16'h0313);
    peer.send(9'h0b1, 4'h8);
    waitFor(1, r + 1, 100);
    rd(ADDR_RBUF, v);
    chk(v, 16'h00b1);
    wr(ADDR_CTRL, 16'h0317);
    peer.send(9'h183, 4'h9);
    waitFor(1, r + 2, 100);
    rd(ADDR_RBUF, v);
    chk(v, 16'h0183);
    chk(16'(errCnt - e), 16'h0000);
    wr(ADDR_CTRL, 16'h0313);
    peer.send(9'h031, 4'h8);
    waitFor(1, r + 3, 100);
    rd(ADDR_CTRL, v);
    chk({15'h0000, v[C_PE]}, 16'h0001);
    chk(16'(errCnt - e), 16'h0001);
    rd(ADDR_RBUF, v);
    wr(ADDR_CTRL, 16'h0201);
    peer.send(9'h077, 4'h8);
    chk(16'(rxCnt - r), 16'h0003);
  endtask : t_rx
  task automatic t_ovr();
    logic [15:0] v;
    int r;
    int e;
    r = rxCnt;
    e = errCnt;
    wr(ADDR_CTRL, 16'h0341);
    peer.send(9'h011, 4'h8);
    peer.send(9'h022, 4'h8);
    waitFor(1, r + 2, 100);
    rd(ADDR_CTRL, v);
    chk({15'h0000, v[C_OE]}, 16'h0001);
    chk(16'(errCnt - e), 16'h0001);
    rd(ADDR_RBUF, v);
    chk(v, 16'h0022);
  endtask : t_ovr
  task automatic t_loop();
    logic [15:0] v;
    int r;
    r = rxCnt;
    wr(ADDR_CTRL, 16'h0381);
    wr(ADDR_TBUF, 16'h003c);
    waitFor(1, r + 1, 600);
    rd(ADDR_RBUF, v);
    chk(v, 16'h003c);
  endtask : t_loop
  task automatic t_irda();
    int w;
    // let the loop-back stop bit finish before the mode change
    repeat (40) @(posedge clk);
    listen <= 1'b0;
    wr(ADDR_CTRL, 16'h0202);
    wr(ADDR_TBUF, 16'h0000);
    pulseW(w);
    chk(16'(w), 16'h0006);
    repeat (400) @(posedge clk);
    wr(ADDR_PMW, 16'h0104);
    wr(ADDR_TBUF, 16'h0000);
    pulseW(w);
    chk(16'(w), 16'h0005);
    repeat (400) @(posedge clk);
  endtask : t_irda
  task automatic t_norun();
    int t;
    int bad;
    t = tbeCnt;
    bad = 0;
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_TBUF, 16'h0055);
    repeat (400) begin
      @(negedge clk);
      if (txd !== 1'b1) bad++;
    end
    chk(16'(tbeCnt - t), 16'h0000);
    chk(16'(bad), 16'h0000);
  endtask : t_norun
  task automatic t_sync();
    logic [15:0] v;
    logic [7:0] d;
    logic q;
    int r;
    int f;
    r = rxCnt;
    f = 0;
    q = 1'b1;
    d = '0;
    wr(ADDR_CTRL, 16'h0300);
    wr(ADDR_TBUF, 16'h00a5);
    repeat (200) begin
      @(negedge clk);
      if (q === 1'b1 && sclk === 1'b0) f++;
      if (q === 1'b0 && sclk === 1'b1) d = {txd, d[7:1]};
      q = sclk;
    end
    chk(16'(f), 16'h0008);
    chk({8'h00, d}, 16'h00a5);
    chk(16'(rxCnt - r), 16'h0001);
    rd(ADDR_RBUF, v);
    chk(v, 16'h00ff);
  endtask : t_sync
  task automatic t_ab();
    logic [15:0] v;
    wr(ADDR_BG, 16'h0123);
    wr(ADDR_CTRL, 16'h0e07);
    peer.send(9'h001, 4'h8);
    rd(ADDR_BG, v);
    chk(v, 16'h0000);
    rd(ADDR_STAT, v);
    chk(v, 16'h0010);
    rd(ADDR_CTRL, v);
    chk(v, 16'h0201);
  endtask : t_ab
  // ==========
  // main sequence
  initial begin
    bus = '0;
    rst = 1'b1;
    listen = 1'b0;
    peerBits = 4'h8;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_ovr();
    t_loop();
    t_irda();
    t_sync();
    t_ab();
    t_norun();
    summarize();
  end
endmodule : testbench

// File: rtl/scc_baud.sv
`timescale 1ns/1ps
module scc_baud (
  input logic clk,
  input logic rst,
  input logic run,
  input logic preSel,
  input logic [scc_pkg::BG_W-1:0] reload,
  output logic tick
);
  import scc_pkg::*;

  typedef struct packed {
    logic [1:0] pre;
    logic [BG_W-1:0] cnt;
    logic tick;
  } scc_baud_s;

  scc_baud_s s;
  scc_baud_s n;

  // ==========================================================
  // prescaler then 13-bit reload timer
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.pre = '0;
      n.cnt = reload;
    end else if (s.pre == (preSel ? PRE3_END : PRE2_END)) begin
      n.pre = '0;
      if (s.cnt == '0) begin
        n.cnt = reload;
        n.tick = 1'b1;
      end else begin
        n.cnt = s.cnt - BG_ONE;
      end
    end else begin
      n.pre = s.pre + PRE_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;

endmodule : scc_baud

// File: rtl/scc_channel.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module scc_channel (
  input logic clk,
  input logic rst,
  input scc_pkg::scc_bus_s bus,
  output logic [scc_pkg::DW-1:0] rdata,
  input logic rxd,
  output logic txd,
  output logic sclk,
  output logic tbEmpty,
  output logic rxDone,
  output logic errIrq
);
  import scc_pkg::*;
  typedef struct packed {
    logic [DW-1:0] ctrl;
    logic [BG_W-1:0] bg;
    logic [PMW_W-1:0] pmw;
    logic [DAT_W-1:0] tbuf;
    logic tbFull;
    scc_tx_e txSt;
    logic [PH_W-1:0] txPh;
    logic [CNT_W-1:0] txCnt;
    logic [DAT_W-1:0] txSr;
    logic txLine;
    logic txStop;
    logic txPin;
    logic sclk;
    logic [DAT_W-1:0] rbuf;
    logic rbFull;
    scc_rx_e rxSt;
    logic [PH_W-1:0] rxPh;
    logic [CNT_W-1:0] rxCnt;
    logic [DAT_W-1:0] rxSr;
    logic v0;
    logic v1;
    logic rxStop;
    logic rxFe;
    logic abMeas;
    logic abPrev;
    logic abDone;
    logic [AB_W-1:0] abCnt;
    logic [DW-1:0] rdata;
    logic tbEmpty;
    logic rxDone;
    logic errIrq;
  } scc_state_s;
  scc_state_s s;
  scc_state_s n;
  // ==========================================================
  // control decode
  logic [2:0] mode;
  logic run;
  logic ren;
  logic syncMode;
  logic irMode;
  logic tick;
  logic irTx;
  logic irRx;
  logic rxIn;
  logic [STAT_W-1:0] stat;
  logic [PH_W:0] txSum;
  logic txEnd;
  logic doLoad;
  logic deliver;
  logic bit1;
  logic [DAT_W-1:0] frame;
  logic [DAT_W-1:0] dat;
  logic nine;
  logic parErr;
  logic ovr;
  assign mode = s.ctrl[C_MODE_HI:C_MODE_LO];
  assign run = s.ctrl[C_RUN];
  assign ren = s.ctrl[C_REN];
  assign syncMode = (mode == M_SYNC);
  assign irMode = (mode == M_IRDA);
  // async loop-back takes the unencoded line, pins are not involved
  assign rxIn = s.ctrl[C_LB] ? s.txLine : (irMode ? irRx : rxd);
  always_comb begin
    stat = '0;
    stat[S_RBF] = s.rbFull;
    stat[S_TBF] = s.tbFull;
    stat[S_TXB] = (s.txSt != TX_IDLE);
    stat[S_RXB] = (s.rxSt != RX_IDLE);
    stat[S_ABD] = s.abDone;
  end
  // transmit frame with parity placed per mode
  always_comb begin
    frame = s.tbuf;
    if (mode == M_A7P) begin
      frame = {1'b0, scc_par(s.tbuf, 1'b0, s.ctrl[C_ODD]), s.tbuf[6:0]};
    end else if (mode == M_A8P) begin
      frame = {scc_par(s.tbuf, 1'b1, s.ctrl[C_ODD]), s.tbuf[7:0]};
    end
  end
  scc_baud u_baud (
    .clk(clk),
    .rst(rst),
    .run(run),
    .preSel(s.ctrl[C_BRS]),
    .reload(s.bg),
    .tick(tick)
  );
  scc_irda u_irda (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .txBit(s.txLine),
    .phase(s.txPh),
    .progMode(s.pmw[PMW_PULSE_WIDTH_MODE_SEL]),
    .pwCount(s.pmw[PW_W-1:0]),
    .rxPin(rxd),
    .irTx(irTx),
    .irRx(irRx)
  );
  // sync mode steps half a cell per tick, async one sixteenth
  assign txSum = {1'b0, s.txPh} + (syncMode ? STEP_SYNC : STEP_ASYNC);
  assign txEnd = tick && txSum[PH_W];
  always_comb begin
    n = s;
    n.tbEmpty = 1'b0;
    n.rxDone = 1'b0;
    n.errIrq = 1'b0;
    n.rdata = '0;
    doLoad = 1'b0;
    deliver = 1'b0;
    bit1 = scc_maj(s.v0, s.v1, rxIn);
    dat = '0;
    nine = 1'b0;
    parErr = 1'b0;
    ovr = 1'b0;
    // ========================================================
    // register reads and control writes
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: n.rdata = s.ctrl;
        ADDR_BG: n.rdata = DW'(s.bg);
        ADDR_PMW: n.rdata = DW'(s.pmw);
        ADDR_TBUF: n.rdata = DW'(s.tbuf);
        ADDR_RBUF: begin
          n.rdata = DW'(s.rbuf);
          n.rbFull = 1'b0;
        end
        ADDR_STAT: begin
          n.rdata = DW'(stat);
          n.abDone = 1'b0;
        end
        default: n.rdata = '0;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: n.ctrl = bus.wdata & CTRL_WMASK;
        ADDR_BG: n.bg = bus.wdata[BG_W-1:0];
        ADDR_PMW: n.pmw = bus.wdata[PMW_W-1:0];
        default: ;
      endcase
    end
    // ========================================================
    // transmitter
    if (tick && s.txSt != TX_IDLE) begin
      n.txPh = txSum[PH_W-1:0];
    end
    if (syncMode && tick && s.txSt == TX_DATA && ren &&
        txSum[PH_W-1:0] == PH_SYNC_SMP) begin
      n.rxSr = {rxd, s.rxSr[DAT_W-1:1]};
    end
    unique case (s.txSt)
      TX_IDLE: doLoad = run && s.tbFull;
      TX_START: begin
        if (txEnd) begin
          n.txSt = TX_DATA;
          n.txLine = s.txSr[0];
        end
      end
      TX_DATA: begin
        if (txEnd) begin
          n.txSr = s.txSr >> 1;
          n.txCnt = s.txCnt - CNT_ONE;
          if (s.txCnt != CNT_LAST) begin
            n.txLine = s.txSr[1];
          end else if (syncMode) begin
            n.txLine = 1'b1;
            deliver = ren;
            doLoad = run && s.tbFull;
            n.txSt = TX_IDLE;
          end else begin
            n.txLine = 1'b1;
            n.txSt = TX_STOP;
            n.txStop = s.ctrl[C_STP];
          end
        end
      end
      TX_STOP: begin
        if (txEnd) begin
          if (s.txStop) begin
            n.txStop = 1'b0;
          end else begin
            doLoad = run && s.tbFull;
            n.txSt = TX_IDLE;
          end
        end
      end
      default: n.txSt = TX_IDLE;
    endcase
    if (doLoad) begin
      // only mode-width bits ever reach the line
      n.txSr = frame;
      n.txCnt = syncMode ? NB_8 : scc_nbits(mode);
      n.tbFull = 1'b0;
      n.tbEmpty = 1'b1;
      n.txPh = '0;
      n.txSt = syncMode ? TX_DATA : TX_START;
      n.txLine = syncMode ? frame[0] : 1'b0;
    end
    // shift clock low in first half of each sync cell
    n.sclk = !(syncMode && n.txSt == TX_DATA) || n.txPh[PH_W-1];
    // ========================================================
    // asynchronous receiver, 3-sample vote
    unique case (s.rxSt)
      RX_IDLE: begin
        if (run && ren && !syncMode && !s.ctrl[C_ABEN] && !rxIn) begin
          n.rxSt = RX_START;
          n.rxPh = '0;
          n.rxFe = 1'b0;
        end
      end
      RX_START, RX_DATA, RX_STOP: begin
        if (tick) begin
          n.rxPh = s.rxPh + PH_ONE;
          if (s.rxPh == PH_V0) n.v0 = rxIn;
          if (s.rxPh == PH_V1) n.v1 = rxIn;
          if (s.rxPh == PH_DEC) begin
            if (s.rxSt == RX_START) begin
              // glitch instead of start bit: back to hunting
              n.rxSt = bit1 ? RX_IDLE : RX_DATA;
              n.rxCnt = scc_nbits(mode);
            end else if (s.rxSt == RX_DATA) begin
              n.rxSr = {bit1, s.rxSr[DAT_W-1:1]};
              n.rxCnt = s.rxCnt - CNT_ONE;
              if (s.rxCnt == CNT_LAST) begin
                n.rxSt = RX_STOP;
                n.rxStop = s.ctrl[C_STP];
              end
            end else begin
              n.rxFe = s.rxFe | !bit1;
              if (s.rxStop) begin
                n.rxStop = 1'b0;
              end else begin
                deliver = 1'b1;
                n.rxSt = RX_IDLE;
              end
            end
          end
        end
      end
      default: n.rxSt = RX_IDLE;
    endcase
    // ========================================================
    // hand a finished character to the receive holding reg
    if (deliver) begin
      nine = !syncMode && scc_nbits(mode) == NB_9;
      dat = nine ? n.rxSr : {1'b0, n.rxSr[DAT_W-1:1]};
      if (s.ctrl[C_PEN] && mode == M_A7P) begin
        parErr = dat[7] != scc_par(dat, 1'b0, s.ctrl[C_ODD]);
      end else if (s.ctrl[C_PEN] && mode == M_A8P) begin
        parErr = dat[8] != scc_par(dat, 1'b1, s.ctrl[C_ODD]);
      end
      // wake-up mode drops data characters without rxDone, though a bad stop bit still sets FE and errIrq
      if (mode != M_WAKE || dat[8]) begin
        ovr = n.rbFull && s.ctrl[C_OEN];
        n.rbuf = dat;
        n.rbFull = 1'b1;
        n.rxDone = 1'b1;
      end
      // hardware set wins over a software clear
      n.ctrl[C_PE] = n.ctrl[C_PE] | parErr;
      n.ctrl[C_FE] = n.ctrl[C_FE] | (n.rxFe && !syncMode);
      n.ctrl[C_OE] = n.ctrl[C_OE] | ovr;
      n.errIrq = parErr | (n.rxFe && !syncMode) | ovr;
    end
    // ========================================================
    // autobaud: time the start bit of an 'a' style char
    // assumes the /2 prescaler, so it forces that choice
    n.abPrev = rxd;
    if (s.ctrl[C_ABEN]) begin
      if (!s.abMeas) begin
        if (s.abPrev && !rxd) begin
          n.abMeas = 1'b1;
          n.abCnt = AB_ONE; // detect cycle already saw the line low
        end
      end else if (rxd) begin
        n.abMeas = 1'b0;
        n.bg = BG_W'(s.abCnt >> AB_SHIFT) - BG_ONE;
        n.ctrl[C_MODE_HI:C_MODE_LO] = M_A8;
        n.ctrl[C_BRS] = 1'b0;
        n.ctrl[C_ABEN] = 1'b0;
        n.abDone = 1'b1;
      end else begin
        n.abCnt = s.abCnt + AB_ONE;
      end
    end else begin
      n.abMeas = 1'b0;
    end
    // transmit holding write last: a load this cycle used old data
    if (bus.wr && bus.addr == ADDR_TBUF) begin
      n.tbuf = bus.wdata[DAT_W-1:0];
      n.tbFull = 1'b1;
    end
    // IrDA idles dark, plain UART idles high
    if (s.ctrl[C_LB]) begin
      n.txPin = !irMode;
    end else begin
      n.txPin = irMode ? irTx : s.txLine;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.txSt <= TX_IDLE;
      s.rxSt <= RX_IDLE;
      s.txLine <= 1'b1;
      s.txPin <= 1'b1;
      s.sclk <= 1'b1;
      s.abPrev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign txd = s.txPin;
  assign sclk = s.sclk;
  assign tbEmpty = s.tbEmpty;
  assign rxDone = s.rxDone;
  assign errIrq = s.errIrq;

endmodule : scc_channel

// File: rtl/scc_irda.sv
`timescale 1ns/1ps
module scc_irda (
  input logic clk,
  input logic rst,
  input logic tick,
  input logic txBit,
  input logic [scc_pkg::PH_W-1:0] phase,
  input logic progMode,
  input logic [scc_pkg::PW_W-1:0] pwCount,
  input logic rxPin,
  output logic irTx,
  output logic irRx
);
  import scc_pkg::*;

  typedef struct packed {
    logic pwOn;
    logic [PW_W-1:0] pwCnt;
    logic irTx;
    logic [4:0] stretch;
    logic irRx;
  } scc_irda_s;

  scc_irda_s s;
  scc_irda_s n;
  logic fixedOn;

  // ==========================================================
  // encoder: zero bits give a high pulse from mid cell
  assign fixedOn = !txBit && phase >= IR_LO && phase <= IR_HI;

  always_comb begin
    n = s;
    if (tick && phase == IR_PRE && !txBit) begin
      n.pwOn = 1'b1;
      n.pwCnt = '0;
    end else if (s.pwOn) begin
      if (s.pwCnt == pwCount) begin
        n.pwOn = 1'b0;
      end else begin
        n.pwCnt = s.pwCnt + PW_ONE;
      end
    end
    n.irTx = progMode ? n.pwOn : fixedOn;
    // decoder: stretch short pulses over the vote window
    if (rxPin) begin
      n.stretch = IR_STRETCH;
    end else if (tick && s.stretch != '0) begin
      n.stretch = s.stretch - STRETCH_ONE;
    end
    n.irRx = (n.stretch == '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.irRx <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign irTx = s.irTx;
  assign irRx = s.irRx;

endmodule : scc_irda

// File: rtl/scc_pkg.sv
package scc_pkg;
  // ==========================================================
  // widths
  localparam int DW = 16;
  localparam int BG_W = 13;
  localparam int PW_W = 8;
  localparam int PMW_W = 9;
  localparam int DAT_W = 9;
  localparam int PH_W = 4;
  localparam int CNT_W = 4;
  localparam int AB_W = 18;
  localparam int STAT_W = 5;

  // ==========================================================
  // register bus
  typedef struct packed {
    logic [3:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } scc_bus_s;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BG = 4'h1;
  localparam logic [3:0] ADDR_PMW = 4'h2;
  localparam logic [3:0] ADDR_TBUF = 4'h3;
  localparam logic [3:0] ADDR_RBUF = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h5;

  // ==========================================================
  // control register fields
  localparam int C_MODE_LO = 0;
  localparam int C_MODE_HI = 2;
  localparam int C_STP = 3;
  localparam int C_PEN = 4;
  localparam int C_ODD = 5;
  localparam int C_OEN = 6;
  localparam int C_LB = 7;
  localparam int C_REN = 8;
  localparam int C_RUN = 9;
  localparam int C_BRS = 10;
  localparam int C_ABEN = 11;
  localparam int C_PE = 12;
  localparam int C_FE = 13;
  localparam int C_OE = 14;
  localparam logic [DW-1:0] CTRL_WMASK = 16'h7fff;
  localparam int PMW_PULSE_WIDTH_MODE_SEL = 8;

  // status register fields
  localparam int S_RBF = 0;
  localparam int S_TBF = 1;
  localparam int S_TXB = 2;
  localparam int S_RXB = 3;
  localparam int S_ABD = 4;

  // ==========================================================
  // frame modes
  localparam logic [2:0] M_SYNC = 3'h0;
  localparam logic [2:0] M_A8 = 3'h1;
  localparam logic [2:0] M_IRDA = 3'h2;
  localparam logic [2:0] M_A7P = 3'h3;
  localparam logic [2:0] M_A9 = 3'h4;
  localparam logic [2:0] M_WAKE = 3'h5;
  localparam logic [2:0] M_A8P = 3'h7;

  // ==========================================================
  // timing
  localparam logic [CNT_W-1:0] NB_8 = 4'h8;
  localparam logic [CNT_W-1:0] NB_9 = 4'h9;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [PH_W-1:0] PH_ONE = 4'h1;
  localparam logic [PH_W-1:0] PH_V0 = 4'h7;
  localparam logic [PH_W-1:0] PH_V1 = 4'h8;
  localparam logic [PH_W-1:0] PH_DEC = 4'h9;
  localparam logic [PH_W:0] STEP_ASYNC = 5'h01;
  localparam logic [PH_W:0] STEP_SYNC = 5'h08;
  localparam logic [PH_W-1:0] PH_SYNC_SMP = 4'h8;
  localparam logic [PH_W-1:0] IR_PRE = 4'h7;
  localparam logic [PH_W-1:0] IR_LO = 4'h8;
  localparam logic [PH_W-1:0] IR_HI = 4'ha;
  localparam logic [4:0] IR_STRETCH = 5'h10;
  localparam logic [4:0] STRETCH_ONE = 5'h01;
  localparam logic [PW_W-1:0] PW_ONE = 8'h01;
  localparam logic [1:0] PRE2_END = 2'h1;
  localparam logic [1:0] PRE3_END = 2'h2;
  localparam logic [1:0] PRE_ONE = 2'h1;
  localparam logic [BG_W-1:0] BG_ONE = 13'h0001;
  localparam int AB_SHIFT = 5;
  localparam logic [AB_W-1:0] AB_ONE = 18'h0_0001;

  // ==========================================================
  // engine states
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } scc_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } scc_rx_e;

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] scc_nbits(input logic [2:0] m);
    return (m == M_A9 || m == M_WAKE || m == M_A8P) ? NB_9 : NB_8;
  endfunction : scc_nbits

  function automatic logic scc_par(input logic [DAT_W-1:0] d,
                                   input logic nine, input logic odd);
    return nine ? (^d[7:0]) ^ odd : (^d[6:0]) ^ odd;
  endfunction : scc_par

  function automatic logic scc_maj(input logic a, input logic b,
                                   input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : scc_maj

endpackage : scc_pkg
